// ---- verilog/aapr_pkg.sv ----
package aapr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, one aligned 32-bit word per register.
   localparam logic [7:0] OFS_ACK_CTRL = 8'h00;
   localparam logic [7:0] OFS_SEED_1 = 8'h04;
   localparam logic [7:0] OFS_RX_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   // Fields of ack_frame_control_1.
   localparam int BIT_PROMISC = 1;
   localparam int BIT_TURN = 2;
   localparam logic [7:0] CTRL_RW_MASK = 8'h36;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Fields of backoff_seed_reg_1 and rx_signal_status_reg.
   localparam int BIT_ACK_SUPPRESS = 4;
   localparam logic [7:0] SEED_RST = 8'h00;
   localparam int BIT_CRC_VALID = 7;

   // Interrupt events.
   localparam int IRQ_N = 2;
   localparam int IRQ_RX_END = 0;
   localparam int IRQ_ACK_TX = 1;
   localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Turnaround timing at a 40 MHz pclk.
   localparam int CLK_PERIOD_NS = 25;
   localparam int SYMBOL_NS = 16000;
   localparam int SYMBOL_CYC = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_LONG_SYM = 12;
   localparam int ACK_SHORT_SYM = 2;
   localparam int ACK_LONG_CYC = ACK_LONG_SYM * SYMBOL_CYC;
   localparam int ACK_SHORT_CYC = ACK_SHORT_SYM * SYMBOL_CYC;
   localparam int ACK_CNT_W = 13;

   // Outcome of one frame, reported by the receiver at its last symbol.
   typedef struct packed {
      logic done;
      logic phr_valid;
      logic filter_pass;
      logic fcs_ok;
      logic ack_request;
   } aapr_rx_frame_t;

endpackage

// ---- verilog/aapr_turnaround_timer.sv ----
`timescale 1ns/100ps
module aapr_turnaround_timer
   import aapr_pkg::*;
#(
   parameter int CNT_W = ACK_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_val,
   output logic busy,
   output logic fire
);

   logic busy_q;
   logic [CNT_W-1:0] cnt_q;

   // A new load restarts the wait, so a fresh frame always wins over a stale one.
   assign fire = busy_q && (cnt_q == CNT_W'(1));
   assign busy = busy_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
      end else if (load) begin
         busy_q <= 1'b1;
         cnt_q <= load_val;
      end else if (fire) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - CNT_W'(1);
      end
   end

endmodule

// ---- verilog/aapr_irq_ctrl.sv ----
`timescale 1ns/100ps
module aapr_irq_ctrl
   import aapr_pkg::*;
#(
   parameter int N = IRQ_N
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] event_in,
   input wire logic status_we,
   input wire logic mask_we,
   input wire logic [N-1:0] wdata,
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);

   logic [N-1:0] status_q;
   logic [N-1:0] mask_q;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // An event in the cycle of its clear keeps the bit set.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               status_q[i] <= IRQ_RST[i];
            end else if (event_in[i]) begin
               status_q[i] <= 1'b1;
            end else if (status_we && wdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= IRQ_RST;
      end else if (mask_we) begin
         mask_q <= wdata;
      end
   end

   assign status = status_q;
   assign mask = mask_q;
   assign irq = |(status_q & mask_q);

endmodule

// ---- verilog/aapr_rx_ctrl.sv ----
`timescale 1ns/100ps
module aapr_rx_ctrl
   import aapr_pkg::*;
#(
   parameter int ACK_LONG_CYC_P = ACK_LONG_CYC,
   parameter int ACK_SHORT_CYC_P = ACK_SHORT_CYC,
   parameter int CNT_W = ACK_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic auto_ack_receive_mode,
   input wire aapr_rx_frame_t rx_frame,
   output logic rx_end,
   output logic ack_tx_start,
   output logic ack_busy,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic [7:0] ctrl_q;
   logic [7:0] seed_q;
   logic crc_valid_q;
   logic rx_end_q;
   logic [31:0] prdata_q;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_mask;
   logic [IRQ_N-1:0] irq_event;

   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire hit_ctrl = (paddr == OFS_ACK_CTRL);
   wire hit_seed = (paddr == OFS_SEED_1);
   wire hit_rxst = (paddr == OFS_RX_STATUS);
   wire hit_ists = (paddr == OFS_IRQ_STATUS);
   wire hit_imsk = (paddr == OFS_IRQ_MASK);
   wire mapped = hit_ctrl || hit_seed || hit_rxst || hit_ists || hit_imsk;

   // Every access completes in its first access cycle.
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = prdata_q;

   // Reserved control bits are masked out, so they read as zero.
   wire [7:0] ctrl_rd = ctrl_q & CTRL_RW_MASK;
   wire [7:0] rxst_rd = {crc_valid_q, 7'h00};
   wire [31:0] read_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                          hit_seed ? {24'h000000, seed_q} :
                          hit_rxst ? {24'h000000, rxst_rd} :
                          hit_ists ? {{(32-IRQ_N){1'b0}}, irq_status} :
                          hit_imsk ? {{(32-IRQ_N){1'b0}}, irq_mask} : 32'h00000000;

   // Read data is captured in the setup cycle so that prdata comes from a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata_q <= read_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr && hit_ctrl) begin
         // Reserved positions are never stored, whatever software writes.
         ctrl_q <= pwdata[7:0] & CTRL_RW_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seed_q <= SEED_RST;
      end else if (wr && hit_seed) begin
         seed_q <= pwdata[7:0];
      end
   end

   wire promisc_enable = ctrl_q[BIT_PROMISC];
   wire ack_turnaround_select = ctrl_q[BIT_TURN];
   wire ack_suppress = seed_q[BIT_ACK_SUPPRESS];

   ////////////////////////////////////////////////////////////////////////////////
   // Frame outcome.

   wire frame_end = rx_frame.done && rx_frame.phr_valid;
   wire frame_good = rx_frame.filter_pass && rx_frame.fcs_ok;
   // Outside auto-ack mode every frame with a valid header is delivered.
   wire deliver = frame_end && (!auto_ack_receive_mode || promisc_enable || frame_good);
   // A frame with a bad checksum is never acknowledged, even in promiscuous mode.
   wire ack_arm = frame_end && auto_ack_receive_mode && frame_good &&
                  rx_frame.ack_request && !ack_suppress;
   wire [CNT_W-1:0] ack_delay = ack_turnaround_select ? CNT_W'(ACK_SHORT_CYC_P) :
                                CNT_W'(ACK_LONG_CYC_P);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_end_q <= 1'b0;
      end else begin
         rx_end_q <= deliver;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_valid_q <= 1'b0;
      end else if (frame_end) begin
         crc_valid_q <= rx_frame.fcs_ok;
      end
   end

   assign rx_end = rx_end_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledgment turnaround and interrupts.

   aapr_turnaround_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(ack_arm),
      .load_val(ack_delay),
      .busy(ack_busy),
      .fire(ack_tx_start)
   );

   assign irq_event = {ack_tx_start, rx_end_q};

   aapr_irq_ctrl #(
      .N(IRQ_N)
   ) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(irq_event),
      .status_we(wr && hit_ists),
      .mask_we(wr && hit_imsk),
      .wdata(pwdata[IRQ_N-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic [CNT_W-1:0] ack_wait_q;
   logic [CNT_W-1:0] ack_exp_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_wait_q <= '0;
         ack_exp_q <= '0;
      end else if (ack_arm) begin
         ack_wait_q <= CNT_W'(1);
         ack_exp_q <= ack_delay;
      end else if (ack_busy) begin
         ack_wait_q <= ack_wait_q + CNT_W'(1);
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_ctrl_write;
      psel && penable && pwrite && (paddr == OFS_ACK_CTRL);
   endsequence

   sequence s_promisc_frame;
      auto_ack_receive_mode && promisc_enable && rx_frame.done && rx_frame.phr_valid;
   endsequence

   AST_PROMISC_FOLLOWS_WRITE: assert property (
      s_ctrl_write |=> (promisc_enable == $past(pwdata[BIT_PROMISC])))
      else $error("promisc_enable did not follow the control write");

   AST_PROMISC_RX_END: assert property (
      s_promisc_frame |=> rx_end ##1 (!rx_end || $past(frame_end)))
      else $error("promiscuous frame did not give a one-cycle receive end");

   AST_CRC_FLAG: assert property (
      (rx_frame.done && rx_frame.phr_valid) |=> (crc_valid_q == $past(rx_frame.fcs_ok)))
      else $error("checksum-valid flag not updated from the frame");

   AST_ACK_SUPPRESSED: assert property (
      (s_promisc_frame and (ack_suppress && !ack_busy)) |=> !ack_busy)
      else $error("acknowledgment started while suppressed");

   AST_ACK_ARMED: assert property (
      (s_promisc_frame and (frame_good && rx_frame.ack_request && !ack_suppress))
      |=> ack_busy && ack_wait_q == CNT_W'(1))
      else $error("acknowledgment not armed for a filter-passing frame");

   AST_RESERVED_READ: assert property (
      (psel && penable && !pwrite && (paddr == OFS_ACK_CTRL)) |-> (prdata[0] == 1'b0))
      else $error("reserved control bit read back nonzero");

   AST_ACK_TURNAROUND: assert property (
      ack_tx_start |-> (ack_wait_q == ack_exp_q &&
         (ack_exp_q == CNT_W'(ACK_SHORT_CYC_P) || ack_exp_q == CNT_W'(ACK_LONG_CYC_P))))
      else $error("acknowledgment start not at the turnaround time");

   AST_ACK_NOT_LATE: assert property (
      ack_busy |-> (ack_wait_q <= ack_exp_q))
      else $error("acknowledgment wait ran past the turnaround time");

   AST_NO_RX_END_FILTERED: assert property (
      (auto_ack_receive_mode && !promisc_enable && rx_frame.done && !frame_good)
      |=> !rx_end)
      else $error("receive end raised for a rejected frame");

   // Helper terms for the checks below; a clear of status bit 0 and a write that decodes nowhere.
   wire ists_clear0 = wr && hit_ists && pwdata[IRQ_RX_END];
   wire unmapped_wr = wr && !mapped;

   sequence s_arm_short;
      ack_arm && ack_turnaround_select;
   endsequence

   sequence s_arm_long;
      ack_arm && !ack_turnaround_select;
   endsequence

   // The turnaround is far longer than a delay range may span, so the wait is checked by count.
   AST_ARM_SHORT: assert property (
      s_arm_short |=> (ack_busy && ack_exp_q == CNT_W'(ACK_SHORT_CYC_P)))
      else $error("short turnaround not loaded for an acknowledged frame");

   AST_ARM_LONG: assert property (
      s_arm_long |=> (ack_busy && ack_exp_q == CNT_W'(ACK_LONG_CYC_P)))
      else $error("long turnaround not loaded for an acknowledged frame");

   AST_ACK_START_PULSE: assert property (
      (ack_tx_start && !ack_arm) |=> !ack_tx_start)
      else $error("acknowledgment start lasted more than one cycle");

   AST_ACK_BUSY_ENDS: assert property (
      (ack_tx_start && !ack_arm) |=> !ack_busy)
      else $error("turnaround wait did not end at the acknowledgment start");

   AST_RX_END_NEEDS_FRAME: assert property (
      !frame_end |=> !rx_end)
      else $error("receive end raised without a frame end");

   AST_RX_END_OPEN_MODE: assert property (
      (frame_end && !auto_ack_receive_mode) |=> rx_end)
      else $error("frame outside auto-ack mode not delivered");

   AST_CRC_HOLDS: assert property (
      !frame_end |=> $stable(crc_valid_q))
      else $error("checksum-valid flag changed without a frame");

   AST_NO_ACK_BAD_FCS: assert property (
      (frame_end && !rx_frame.fcs_ok && !ack_busy) |=> !ack_busy)
      else $error("acknowledgment armed for a bad checksum");

   AST_NO_ACK_FILTER_FAIL: assert property (
      (s_promisc_frame and (!rx_frame.filter_pass && !ack_busy)) |=> !ack_busy)
      else $error("acknowledgment armed for a frame that failed filtering");

   AST_RESERVED_NOT_STORED: assert property (
      (ctrl_q & ~CTRL_RW_MASK) == 8'h00)
      else $error("reserved control bit was stored");

   AST_UNMAPPED_WRITE_IGNORED: assert property (
      unmapped_wr |=> ($stable(ctrl_q) && $stable(seed_q) && $stable(irq_mask)))
      else $error("write to an unmapped address changed a register");

   // An event and its clear in one cycle must leave the bit set, or an interrupt is lost.
   AST_STATUS_SET_WINS: assert property (
      (rx_end_q && ists_clear0) |=> irq_status[IRQ_RX_END])
      else $error("receive-end status lost to a clear in the same cycle");

   AST_STATUS_CLEARS: assert property (
      (!rx_end_q && ists_clear0) |=> !irq_status[IRQ_RX_END])
      else $error("receive-end status not cleared by a write of one");

endmodule

// ---- verification/aapr_peer_model.sv ----
`timescale 1ns/100ps
// Far-end radio peer: reports one frame outcome per request at its last symbol.
module aapr_peer_model
   import aapr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [3:0] kind,
   output aapr_rx_frame_t rx_frame
);
   ////////////////////////////////////////////////////////////////////////////////
   // Fields outside the done cycle are toggled so a stale outcome is never reused.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_frame <= '0;
      end else if (go) begin
         rx_frame <= {1'b1, kind};
      end else begin
         rx_frame <= {1'b0, ~rx_frame[3:0]};
      end
   end
endmodule

// ---- verification/tb_auto_ack_promiscuous_rx_control.sv ----
`timescale 1ns/100ps
module tb_auto_ack_promiscuous_rx_control;
   import aapr_pkg::*;
   localparam int LNG = 20;
   localparam int SHT = 6;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, rx_end, ack_tx_start, ack_busy, irq, er;
   logic [31:0] prdata, rd;
   logic mode = 1'b1;
   logic go = 1'b0;
   logic [3:0] kind = 4'h0;
   aapr_rx_frame_t rx_frame;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   aapr_rx_ctrl #(.ACK_LONG_CYC_P(LNG), .ACK_SHORT_CYC_P(SHT), .CNT_W(ACK_CNT_W)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .auto_ack_receive_mode(mode), .rx_frame(rx_frame), .rx_end(rx_end),
      .ack_tx_start(ack_tx_start), .ack_busy(ack_busy), .irq(irq));

   aapr_peer_model peer (.pclk(pclk), .presetn(presetn), .go(go), .kind(kind),
      .rx_frame(rx_frame));

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The slave latency is not assumed; the access phase lasts until pready.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Configures, sends one frame and checks delivery, ack timing, status and interrupt.
   task frame(input logic m, input logic [7:0] c, input logic [7:0] s, input logic [3:0] k,
      input logic ee, input logic ea);
      int n;
      apb(1'b1, OFS_ACK_CTRL, {24'h0, c});
      apb(1'b1, OFS_SEED_1, {24'h0, s});
      apb(1'b1, OFS_IRQ_STATUS, 32'h3);
      n = c[BIT_TURN] ? SHT : LNG;
      @(posedge pclk);
      mode <= m;
      go <= 1'b1;
      kind <= k;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      #1;
      chk({30'h0, ack_busy, rx_end}, {30'h0, ea, ee});
      repeat (n - 2) @(posedge pclk);
      #1;
      chk({31'h0, ack_tx_start}, 32'h0);
      @(posedge pclk);
      #1;
      chk({31'h0, ack_tx_start}, {31'h0, ea});
      apb(1'b0, OFS_RX_STATUS, 32'h0);
      if (k[3]) begin
         chk({31'h0, rd[BIT_CRC_VALID]}, {31'h0, k[1]});
      end
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(rd, {30'h0, ea, ee});
      chk({31'h0, irq}, {31'h0, ee | ea});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out;
      end
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i != 2) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
         end
      end
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, OFS_ACK_CTRL, 32'h36);
      apb(1'b0, OFS_ACK_CTRL, 32'h0);
      chk(rd, {24'h0, CTRL_RW_MASK});
      apb(1'b1, OFS_IRQ_MASK, 32'h3);
      frame(1'b1, 8'h00, 8'h00, 4'hf, 1'b1, 1'b1);
      frame(1'b1, 8'h00, 8'h00, 4'hb, 1'b0, 1'b0);
      frame(1'b1, 8'h00, 8'h00, 4'hd, 1'b0, 1'b0);
      frame(1'b1, 8'h02, 8'h00, 4'hb, 1'b1, 1'b0);
      frame(1'b1, 8'h02, 8'h00, 4'hd, 1'b1, 1'b0);
      frame(1'b1, 8'h02, 8'h00, 4'hf, 1'b1, 1'b1);
      frame(1'b1, 8'h02, 8'h00, 4'h7, 1'b0, 1'b0);
      frame(1'b1, 8'h06, 8'h00, 4'hf, 1'b1, 1'b1);
      frame(1'b1, 8'h02, 8'h10, 4'hf, 1'b1, 1'b0);
      frame(1'b1, 8'h02, 8'h00, 4'he, 1'b1, 1'b0);
      frame(1'b0, 8'h00, 8'h00, 4'hb, 1'b1, 1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      #1;
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_STATUS, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h0);
      close_out;
   end
endmodule
